// ==== fbo_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbo_top (
  // clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST,
  // frame selection
  input  wire logic                          SEL_DRAW_VALID,
  input  wire logic [fbo_pkg::FIDX_W-1:0]    SEL_DRAW_FRAME,
  input  wire logic                          SEL_DISP_VALID,
  input  wire logic [fbo_pkg::FIDX_W-1:0]    SEL_DISP_FRAME,
  output logic                               SEL_REJECT,
  output logic      [fbo_pkg::FIDX_W-1:0]    DRAW_FRAME,
  output logic      [fbo_pkg::FIDX_W-1:0]    DISP_FRAME,
  // drawing writes
  input  wire logic                          DRAW_WE,
  input  wire logic [fbo_pkg::X_W-1:0]       DRAW_X,
  input  wire logic [fbo_pkg::Y_W-1:0]       DRAW_Y,
  input  wire logic [31:0]                   DRAW_PIXEL,
  // scan-out
  input  wire logic                          SCAN_FRAME_START,
  input  wire logic                          SCAN_REQ,
  input  wire logic [fbo_pkg::X_W-1:0]       SCAN_X,
  input  wire logic [fbo_pkg::Y_W-1:0]       SCAN_Y,
  output logic                               SCAN_VALID,
  output logic      [23:0]                   SCAN_RGB,
  // copy and blend operations
  input  wire logic                          OP_START,
  input  wire fbo_pkg::fbo_op_e              OP_KIND,
  input  wire logic [fbo_pkg::FIDX_W-1:0]    OP_SRC,
  input  wire logic [fbo_pkg::FIDX_W-1:0]    OP_DST,
  input  wire logic [fbo_pkg::X_W-1:0]       OP_X0,
  input  wire logic [fbo_pkg::Y_W-1:0]       OP_Y0,
  input  wire logic [fbo_pkg::X_W-1:0]       OP_X1,
  input  wire logic [fbo_pkg::Y_W-1:0]       OP_Y1,
  output logic                               OP_BUSY,
  output logic                               OP_DONE,
  output logic                               OP_REJECT
);
  localparam int unsigned WORDS = fbo_pkg::NUM_FRAMES * fbo_pkg::COLS
                                  * fbo_pkg::ROWS;
  localparam int unsigned WA_W  = fbo_pkg::ADDR_W - 2;

  // one word per pixel across all twenty frames
  logic [31:0] vram [WORDS];

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} fbo_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // frame selections
  logic [fbo_pkg::FIDX_W-1:0] draw_q, draw_d, disp_q, disp_d;
  logic [fbo_pkg::FIDX_W-1:0] pend_q, pend_d;
  logic                       rej_q, rej_d;
  always_comb begin
    draw_d = draw_q;
    pend_d = pend_q;
    disp_d = disp_q;
    rej_d  = 1'b0;
    if (SEL_DRAW_VALID) begin
      if (SEL_DRAW_FRAME <= fbo_pkg::FRAME_LAST) draw_d = SEL_DRAW_FRAME;
      else rej_d = 1'b1;
    end
    if (SEL_DISP_VALID) begin
      if (SEL_DISP_FRAME <= fbo_pkg::FRAME_LAST) pend_d = SEL_DISP_FRAME;
      else rej_d = 1'b1;
    end
    // tearing is avoided by switching only between refreshes
    if (SCAN_FRAME_START) disp_d = pend_q;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      draw_q <= fbo_pkg::FRAME_RESET;
      pend_q <= fbo_pkg::FRAME_RESET;
      disp_q <= fbo_pkg::FRAME_RESET;
      rej_q  <= 1'b0;
    end else begin
      draw_q <= draw_d;
      pend_q <= pend_d;
      disp_q <= disp_d;
      rej_q  <= rej_d;
    end
  end
  // no check ties draw and display apart, so they may be equal
  assign DRAW_FRAME = draw_q;
  assign DISP_FRAME = disp_q;
  assign SEL_REJECT = rej_q;

  ////////////////////////////////////////////////////////////////////////////
  // address generators
  logic [fbo_pkg::ADDR_W-1:0] draw_a, scan_a, src_a, dst_a;
  logic                       draw_ok, scan_ok, src_ok, dst_ok;
  logic [fbo_pkg::X_W-1:0]    cx_q, cx_d;
  logic [fbo_pkg::Y_W-1:0]    cy_q, cy_d;
  logic [fbo_pkg::FIDX_W-1:0] src_q, src_d, dst_q, dst_d;

  fbo_addr u_draw (.frame(draw_q), .x(DRAW_X), .y(DRAW_Y),
                   .addr(draw_a), .valid(draw_ok));
  fbo_addr u_scan (.frame(disp_q), .x(SCAN_X), .y(SCAN_Y),
                   .addr(scan_a), .valid(scan_ok));
  fbo_addr u_src  (.frame(src_q), .x(cx_q), .y(cy_q),
                   .addr(src_a), .valid(src_ok));
  fbo_addr u_dst  (.frame(dst_q), .x(cx_q), .y(cy_q),
                   .addr(dst_a), .valid(dst_ok));

  ////////////////////////////////////////////////////////////////////////////
  // copy and blend engine, one pixel per two cycles
  fbo_state_e              st_q, st_d;
  fbo_pkg::fbo_op_e        kind_q, kind_d;
  logic [fbo_pkg::X_W-1:0] x0_q, x0_d, x1_q, x1_d;
  logic [fbo_pkg::Y_W-1:0] y1_q, y1_d;
  logic [31:0]             sdat_q, sdat_d, ddat_q, ddat_d, res;
  logic                    done_q, done_d, orej_q, orej_d, blend;
  logic                    last_x, last_y;
  always_comb begin
    st_d   = st_q;
    kind_d = kind_q;
    src_d  = src_q;
    dst_d  = dst_q;
    cx_d   = cx_q;
    cy_d   = cy_q;
    x0_d   = x0_q;
    x1_d   = x1_q;
    y1_d   = y1_q;
    sdat_d = sdat_q;
    ddat_d = ddat_q;
    done_d = 1'b0;
    orej_d = 1'b0;
    last_x = (cx_q == x1_q);
    last_y = (cy_q == y1_q);
    blend  = (kind_q == fbo_pkg::OP_BLEND_FRAME)
             || (kind_q == fbo_pkg::OP_BLEND_RECT);
    // blend averages each colour byte; spare byte kept as zero
    res = blend ? {{1'b0, sdat_q[31:25]} + {1'b0, ddat_q[31:25]},
                   {1'b0, sdat_q[23:17]} + {1'b0, ddat_q[23:17]},
                   {1'b0, sdat_q[15:9]}  + {1'b0, ddat_q[15:9]}, 8'h00}
                : sdat_q;
    case (st_q)
      ST_IDLE: begin
        if (OP_START) begin
          kind_d = OP_KIND;
          src_d  = OP_SRC;
          dst_d  = OP_DST;
          if (OP_KIND == fbo_pkg::OP_DUPLICATE_REGION
              || OP_KIND == fbo_pkg::OP_BLEND_RECT) begin
            x0_d = OP_X0;
            x1_d = OP_X1;
            cx_d = OP_X0;
            cy_d = OP_Y0;
            y1_d = OP_Y1;
          end else begin
            x0_d = '0;
            x1_d = fbo_pkg::X_LAST;
            cx_d = '0;
            cy_d = '0;
            y1_d = fbo_pkg::Y_LAST;
          end
          if (OP_SRC > fbo_pkg::FRAME_LAST || OP_DST > fbo_pkg::FRAME_LAST
              || OP_SRC == OP_DST || OP_X0 > OP_X1 || OP_Y0 > OP_Y1
              || OP_X1 > fbo_pkg::X_LAST || OP_Y1 > fbo_pkg::Y_LAST)
            orej_d = 1'b1;
          else st_d = ST_READ;
        end
      end
      ST_READ: begin
        sdat_d = vram[src_a[fbo_pkg::ADDR_W-1:2]];
        ddat_d = vram[dst_a[fbo_pkg::ADDR_W-1:2]];
        st_d   = ST_WRITE;
      end
      ST_WRITE: begin
        st_d = ST_READ;
        if (last_x) begin
          cx_d = x0_q;
          cy_d = cy_q + 1'b1;
          if (last_y) begin
            st_d   = ST_IDLE;
            done_d = 1'b1;
          end
        end else cx_d = cx_q + 1'b1;
      end
      default: st_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q   <= ST_IDLE;
      kind_q <= fbo_pkg::OP_COPY_FRAME;
      src_q  <= fbo_pkg::FRAME_RESET;
      dst_q  <= fbo_pkg::FRAME_RESET;
      cx_q   <= '0;
      cy_q   <= '0;
      x0_q   <= '0;
      x1_q   <= '0;
      y1_q   <= '0;
      sdat_q <= '0;
      ddat_q <= '0;
      done_q <= 1'b0;
      orej_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      kind_q <= kind_d;
      src_q  <= src_d;
      dst_q  <= dst_d;
      cx_q   <= cx_d;
      cy_q   <= cy_d;
      x0_q   <= x0_d;
      x1_q   <= x1_d;
      y1_q   <= y1_d;
      sdat_q <= sdat_d;
      ddat_q <= ddat_d;
      done_q <= done_d;
      orej_q <= orej_d;
    end
  end
  assign OP_DONE   = done_q;
  assign OP_REJECT = orej_q;

  ////////////////////////////////////////////////////////////////////////////
  // memory port: engine write has priority over drawing in the same cycle
  logic busy_q;
  always_ff @(posedge CLK) begin
    if (RST) busy_q <= 1'b0;
    else busy_q <= (st_d != ST_IDLE);
  end
  assign OP_BUSY = busy_q;

  always_ff @(posedge CLK) begin
    if (st_q == ST_WRITE && dst_ok)
      vram[dst_a[fbo_pkg::ADDR_W-1:2]] <= res;
    else if (DRAW_WE && draw_ok)
      vram[draw_a[fbo_pkg::ADDR_W-1:2]] <= DRAW_PIXEL;
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan-out, one cycle latency
  logic [23:0] rgb_q;
  logic        sv_q;
  logic [31:0] sword;
  always_comb sword = vram[scan_a[fbo_pkg::ADDR_W-1:2]];
  always_ff @(posedge CLK) begin
    if (RST) begin
      rgb_q <= '0;
      sv_q  <= 1'b0;
    end else begin
      sv_q  <= SCAN_REQ && scan_ok;
      // red, green, blue sit above the spare byte; the spare byte is dropped
      rgb_q <= sword[fbo_pkg::BLUE_LSB +: 24];
    end
  end
  assign SCAN_RGB   = rgb_q;
  assign SCAN_VALID = sv_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_RESET_ZERO: assert property (@(posedge CLK)
    $past(RST) |-> (DRAW_FRAME == '0 && DISP_FRAME == '0))
    else $error("selection not zero after reset");
  AST_DISP_HOLD: assert property (@(posedge CLK) disable iff (RST)
    !$past(SCAN_FRAME_START) |-> $stable(DISP_FRAME))
    else $error("display frame changed mid refresh");
  AST_DRAW_TAKE: assert property (@(posedge CLK) disable iff (RST)
    (SEL_DRAW_VALID && SEL_DRAW_FRAME <= fbo_pkg::FRAME_LAST)
    |=> DRAW_FRAME == $past(SEL_DRAW_FRAME))
    else $error("draw frame not taken");
  AST_RANGE: assert property (@(posedge CLK) disable iff (RST)
    DRAW_FRAME <= fbo_pkg::FRAME_LAST && DISP_FRAME <= fbo_pkg::FRAME_LAST)
    else $error("frame index out of range");
  AST_BAD_SEL: assert property (@(posedge CLK) disable iff (RST)
    (SEL_DRAW_VALID && SEL_DRAW_FRAME > fbo_pkg::FRAME_LAST)
    |=> SEL_REJECT && $stable(DRAW_FRAME))
    else $error("bad frame not rejected");
  AST_ADDR_MAP: assert property (@(posedge CLK) disable iff (RST)
    draw_ok |-> draw_a == fbo_pkg::ADDR_W'((draw_q * fbo_pkg::COLS
      * fbo_pkg::ROWS + DRAW_Y * fbo_pkg::COLS + DRAW_X) * fbo_pkg::BYTES_PX))
    else $error("pixel address wrong");
  AST_SCAN_LAT: assert property (@(posedge CLK) disable iff (RST)
    (SCAN_REQ && SCAN_X <= fbo_pkg::X_LAST && SCAN_Y <= fbo_pkg::Y_LAST)
    |=> SCAN_VALID)
    else $error("scan answer missing");
  sequence s_op_go;
    st_q == ST_IDLE && OP_START && !OP_REJECT ##1 st_q == ST_READ;
  endsequence
  AST_OP_BUSY: assert property (@(posedge CLK) disable iff (RST)
    s_op_go |-> OP_BUSY ##1 OP_BUSY)
    else $error("operation not busy");
  AST_SAME_REJ: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_IDLE && OP_START && OP_SRC == OP_DST) |=> OP_REJECT)
    else $error("same frame op accepted");
endmodule : fbo_top
`default_nettype wire

// ==== fbo_pkg.sv ====
`default_nettype none
package fbo_pkg;
  localparam int unsigned COLS        = 320;
  localparam int unsigned ROWS        = 240;
  localparam int unsigned NUM_FRAMES  = 20;
  localparam int unsigned BYTES_PX    = 4;
  localparam int unsigned FRAME_BYTES = COLS * ROWS * BYTES_PX;
  localparam int unsigned ADDR_W      = 23;
  localparam int unsigned FIDX_W      = 5;
  localparam int unsigned X_W         = 9;
  localparam int unsigned Y_W         = 8;
  localparam logic [FIDX_W-1:0] FRAME_RESET = 5'h00;
  localparam logic [FIDX_W-1:0] FRAME_LAST  = 5'h13;
  localparam logic [X_W-1:0]    X_LAST      = 9'h13F;
  localparam logic [Y_W-1:0]    Y_LAST      = 8'hEF;
  localparam int unsigned RED_LSB   = 24;
  localparam int unsigned GREEN_LSB = 16;
  localparam int unsigned BLUE_LSB  = 8;
  typedef enum logic [1:0] {
    OP_COPY_FRAME, OP_BLEND_FRAME, OP_DUPLICATE_REGION, OP_BLEND_RECT
  } fbo_op_e;
endpackage : fbo_pkg
`default_nettype wire

// ==== fbo_addr.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbo_addr (
  // pixel location
  input  wire logic [fbo_pkg::FIDX_W-1:0] frame,
  input  wire logic [fbo_pkg::X_W-1:0]    x,
  input  wire logic [fbo_pkg::Y_W-1:0]    y,
  // byte address of red byte
  output logic      [fbo_pkg::ADDR_W-1:0] addr,
  output logic                            valid
);
  logic [fbo_pkg::ADDR_W-1:0] base;
  logic [fbo_pkg::ADDR_W-1:0] pix;
  always_comb begin
    base  = fbo_pkg::ADDR_W'(frame * fbo_pkg::FRAME_BYTES);
    pix   = fbo_pkg::ADDR_W'((y * fbo_pkg::COLS + x) * fbo_pkg::BYTES_PX);
    addr  = base + pix;
    valid = (frame <= fbo_pkg::FRAME_LAST) && (x <= fbo_pkg::X_LAST)
            && (y <= fbo_pkg::Y_LAST);
  end
endmodule : fbo_addr
`default_nettype wire

// ==== fbo_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbo_host_model (
  // clock
  input  wire logic              clk,
  // frame selection
  output logic                   draw_v,
  output logic      [4:0]        draw_f,
  output logic                   disp_v,
  output logic      [4:0]        disp_f,
  input  wire logic              sel_rej,
  // drawing and scan-out
  output logic                   we,
  output logic      [8:0]        wx,
  output logic      [7:0]        wy,
  output logic      [31:0]       wpx,
  output logic                   fstart,
  output logic                   sreq,
  output logic      [8:0]        sx,
  output logic      [7:0]        sy,
  input  wire logic              svalid,
  input  wire logic [23:0]       srgb,
  // copy and blend
  output logic                   ostart,
  output var fbo_pkg::fbo_op_e   okind,
  output logic      [4:0]        osrc,
  output logic      [4:0]        odst,
  output logic      [8:0]        ox0,
  output logic      [7:0]        oy0,
  output logic      [8:0]        ox1,
  output logic      [7:0]        oy1,
  input  wire logic              obusy,
  input  wire logic              odone,
  input  wire logic              orej
);
  logic        rej_q, sv_q, done_q, orej_q, busy_seen;
  logic [23:0] rgb_q;
  initial begin
    {draw_v, draw_f, disp_v, disp_f, we, wx, wy, wpx} = '0;
    {fstart, sreq, sx, sy, ostart, osrc, odst} = '0;
    {ox0, oy0, ox1, oy1} = '0;
    okind = fbo_pkg::OP_COPY_FRAME;
    {rej_q, sv_q, done_q, orej_q, busy_seen, rgb_q} = '0;
  end
  // answers are pulses: keep them until the next request clears them
  always @(posedge clk) begin
    if (sel_rej) rej_q <= 1'b1;
    if (odone) done_q <= 1'b1;
    if (orej) orej_q <= 1'b1;
    if (obusy) busy_seen <= 1'b1;
    if (svalid) begin
      sv_q  <= 1'b1;
      rgb_q <= srgb;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task sel(input logic disp, input logic [4:0] f);
    @(posedge clk);
    rej_q = 1'b0;
    if (disp) begin
      disp_v <= 1'b1;
      disp_f <= f;
    end else begin
      draw_v <= 1'b1;
      draw_f <= f;
    end
    @(posedge clk);
    draw_v <= 1'b0;
    disp_v <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : sel
  task draw(input logic [8:0] x, input logic [7:0] y, input logic [31:0] p);
    @(posedge clk);
    we  <= 1'b1;
    wx  <= x;
    wy  <= y;
    wpx <= p;
    @(posedge clk);
    we <= 1'b0;
  endtask : draw
  task frame_start();
    @(posedge clk);
    fstart <= 1'b1;
    @(posedge clk);
    fstart <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : frame_start
  task scan(input logic [8:0] x, input logic [7:0] y);
    @(posedge clk);
    sv_q = 1'b0;
    sreq <= 1'b1;
    sx   <= x;
    sy   <= y;
    @(posedge clk);
    sreq <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : scan
  task op(input fbo_pkg::fbo_op_e k, input logic [4:0] s, input logic [4:0] d,
          input logic [8:0] x0, input logic [7:0] y0,
          input logic [8:0] x1, input logic [7:0] y1);
    @(posedge clk);
    {done_q, orej_q, busy_seen} = 3'b000;
    ostart <= 1'b1;
    okind  <= k;
    {osrc, odst} <= {s, d};
    {ox0, oy0, ox1, oy1} <= {x0, y0, x1, y1};
    @(posedge clk);
    ostart <= 1'b0;
    // single-pixel rectangles finish in a handful of cycles
    for (int i = 0; i < 20 && !(done_q || orej_q); i++) @(posedge clk);
    #1;
  endtask : op
endmodule : fbo_host_model
`default_nettype wire

// ==== frame_buffer_organizer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module frame_buffer_organizer_tb;
  logic clk, rst;
  logic dv, xv, rej, we, fs, sr, sv, os, bsy, dn, orj;
  logic [4:0] df, xf, dfo, xfo, src, dst;
  logic [8:0] wx, sx, x0, x1;
  logic [7:0] wy, sy, y0, y1;
  logic [31:0] px;
  logic [23:0] rgb;
  fbo_pkg::fbo_op_e kd;
  int fail_count = 0;
  int cmp_count = 0;
  fbo_top dut_u (.CLK(clk), .RST(rst), .SEL_DRAW_VALID(dv),
    .SEL_DRAW_FRAME(df), .SEL_DISP_VALID(xv), .SEL_DISP_FRAME(xf),
    .SEL_REJECT(rej), .DRAW_FRAME(dfo), .DISP_FRAME(xfo), .DRAW_WE(we),
    .DRAW_X(wx), .DRAW_Y(wy), .DRAW_PIXEL(px), .SCAN_FRAME_START(fs),
    .SCAN_REQ(sr), .SCAN_X(sx), .SCAN_Y(sy), .SCAN_VALID(sv), .SCAN_RGB(rgb),
    .OP_START(os), .OP_KIND(kd), .OP_SRC(src), .OP_DST(dst), .OP_X0(x0),
    .OP_Y0(y0), .OP_X1(x1), .OP_Y1(y1), .OP_BUSY(bsy), .OP_DONE(dn),
    .OP_REJECT(orj));
  fbo_host_model h (.clk(clk), .draw_v(dv), .draw_f(df), .disp_v(xv),
    .disp_f(xf), .sel_rej(rej), .we(we), .wx(wx), .wy(wy), .wpx(px),
    .fstart(fs), .sreq(sr), .sx(sx), .sy(sy), .svalid(sv), .srgb(rgb),
    .ostart(os), .okind(kd), .osrc(src), .odst(dst), .ox0(x0), .oy0(y0),
    .ox1(x1), .oy1(y1), .obusy(bsy), .odone(dn), .orej(orj));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task t_select();
    `CHK(dfo, 5'h00)
    `CHK(xfo, 5'h00)
    h.sel(1'b0, 5'h13);
    `CHK(dfo, 5'h13)
    h.sel(1'b0, 5'h14);
    `CHK({h.rej_q, dfo}, {1'b1, 5'h13})
    h.sel(1'b1, 5'h15);
    `CHK({h.rej_q, xfo}, {1'b1, 5'h00})
    h.sel(1'b0, 5'h03);
    h.sel(1'b1, 5'h03);
    `CHK(xfo, 5'h00)
    h.frame_start();
    `CHK({dfo, xfo}, {5'h03, 5'h03})
  endtask : t_select
  task t_pixels();
    h.draw(9'h13F, 8'hEF, 32'h10203040);
    h.draw(9'h000, 8'h01, 32'hAABBCCDD);
    h.draw(9'h13F, 8'h00, 32'h11223344);
    h.draw(9'h140, 8'h00, 32'hFFFFFFFF);
    h.scan(9'h13F, 8'hEF);
    `CHK({h.sv_q, h.rgb_q}, {1'b1, 24'h102030})
    h.scan(9'h000, 8'h01);
    `CHK(h.rgb_q, 24'hAABBCC)
    h.scan(9'h13F, 8'h00);
    `CHK(h.rgb_q, 24'h112233)
    h.scan(9'h140, 8'h00);
    `CHK(h.sv_q, 1'b0)
    h.sel(1'b0, 5'h05);
    h.draw(9'h13F, 8'hEF, 32'h30507099);
    h.scan(9'h13F, 8'hEF);
    `CHK(h.rgb_q, 24'h102030)
  endtask : t_pixels
  task t_ops();
    h.op(fbo_pkg::OP_COPY_FRAME, 5'h03, 5'h03, 9'h000, 8'h00, 9'h000, 8'h00);
    `CHK({h.orej_q, h.done_q}, 2'b10)
    `CHK(h.busy_seen, 1'b0)
    h.op(fbo_pkg::OP_BLEND_FRAME, 5'h14, 5'h03, 9'h000, 8'h00, 9'h000, 8'h00);
    `CHK({h.orej_q, h.done_q}, 2'b10)
    h.op(fbo_pkg::OP_DUPLICATE_REGION, 5'h05, 5'h03, 9'h13F, 8'h00, 9'h13E, 8'h00);
    `CHK({h.orej_q, h.done_q}, 2'b10)
    h.op(fbo_pkg::OP_BLEND_RECT, 5'h05, 5'h03, 9'h13F, 8'hEF, 9'h13F, 8'hEF);
    `CHK({h.orej_q, h.done_q}, 2'b01)
    `CHK({h.busy_seen, bsy}, 2'b10)
    h.scan(9'h13F, 8'hEF);
    // each colour byte is halved before adding, so 30+10 gives 20
    `CHK(h.rgb_q, 24'h203850)
    h.op(fbo_pkg::OP_DUPLICATE_REGION, 5'h05, 5'h03, 9'h13F, 8'hEF, 9'h13F, 8'hEF);
    `CHK({h.orej_q, h.done_q}, 2'b01)
    h.scan(9'h13F, 8'hEF);
    `CHK(h.rgb_q, 24'h305070)
    // a pixel outside the rectangle keeps what was drawn into frame 3
    h.scan(9'h000, 8'h01);
    `CHK(h.rgb_q, 24'hAABBCC)
  endtask : t_ops
  // whole-frame copies take 153600 cycles, too long for this run
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_select();
    t_pixels();
    t_ops();
    end_sim();
  end
  initial begin
    #2000000;
    fail_count++;
    end_sim();
  end
endmodule : frame_buffer_organizer_tb
`default_nettype wire
